// [design/isuh_defs.svh]
// offsets, bit positions, reset values and timing counts of the status block
`ifndef ISUH_DEFS_SVH
`define ISUH_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ISUH_OFS_STATUS 8'h58
`define ISUH_OFS_ENABLE 8'h5C
`define ISUH_OFS_SOURCE 8'h60

// ----------------------------------------------------------------------
// bit positions of the upper half
// ----------------------------------------------------------------------
`define ISUH_BIT_SWI 31
`define ISUH_BIT_READY 30
`define ISUH_BIT_TSU 29
`define ISUH_BIT_FABRIC 28
`define ISUH_BIT_PHY2 27
`define ISUH_BIT_PHY1 26
`define ISUH_BIT_TXHALT 25
`define ISUH_BIT_RXHALT 24
`define ISUH_BIT_DROPHALF 23
`define ISUH_BIT_LOADED 21
`define ISUH_BIT_RXDMA 20
`define ISUH_BIT_TIMER 19
`define ISUH_BIT_POWER 17
`define ISUH_BIT_TRANSMIT_STATUS_OVERFLOW_FLAG 16

// ----------------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------------
`define ISUH_W1C_MASK 16'hC3BB
`define ISUH_RO_MASK 16'h3C00
`define ISUH_STATUS_RST 16'h0000
`define ISUH_ENABLE_RST 16'h0000
`define ISUH_SWREQ_BIT 15

// ----------------------------------------------------------------------
// timing: delay from reset release to device ready
// ----------------------------------------------------------------------
`define ISUH_READY_NS 80
`define ISUH_CLK_NS 8
`define ISUH_READY_CYC ((`ISUH_READY_NS + `ISUH_CLK_NS - 1) / `ISUH_CLK_NS)

`endif

// [design/isuh_pkg.sv]
// types shared by the status block files
package isuh_pkg;

  // ----------------------------------------------------------------------
  // bus slave phase
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    ISUH_IDLE,
    ISUH_ACKED
  } isuh_bus_e;

  typedef logic [15:0] isuh_half_t;

endpackage : isuh_pkg

// [design/isuh_edge.sv]
// rising-edge detector bank for the pulse-free event inputs
`timescale 1ns/1ps
module isuh_edge #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] rise_out
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] last;
    logic [WIDTH-1:0] rise;
  } isuh_edge_s;

  isuh_edge_s st_q;
  isuh_edge_s st_d;

  initial begin
    if (WIDTH < 1) $error("isuh_edge: width must be positive");
  end

  // one compare per bit; a level held high fires only once
  always_comb begin
    st_d = st_q;
    st_d.last = level_in;
    st_d.rise = level_in & ~st_q.last;
  end

  // register the copy
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise_out = st_q.rise;

endmodule : isuh_edge

// [design/isuh_wrap.sv]
// counter watchers: drop counter halfway and timer wrap detection
`timescale 1ns/1ps
module isuh_wrap #(
  parameter int DROP_W = 32,
  parameter int TIMER_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [DROP_W-1:0] drop_count,
  input wire logic [TIMER_W-1:0] general_timer_count,
  output logic drop_half_pulse,
  output logic timer_wrap_pulse
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [DROP_W-1:0] drop_last;
    logic [TIMER_W-1:0] timer_last;
    logic primed;
    logic half;
    logic wrap;
  } isuh_wrap_s;

  isuh_wrap_s st_q;
  isuh_wrap_s st_d;

  initial begin
    if (DROP_W < 2 || TIMER_W < 1) $error("isuh_wrap: bad widths");
  end

  // compare previous and present value; first sample only primes
  always_comb begin
    st_d = st_q;
    st_d.drop_last = drop_count;
    st_d.timer_last = general_timer_count;
    st_d.primed = 1'b1;
    // halfway: 7FFFFFFF to 80000000
    st_d.half = st_q.primed && !st_q.drop_last[DROP_W-1]
      && (&st_q.drop_last[DROP_W-2:0]) && drop_count[DROP_W-1]
      && (drop_count[DROP_W-2:0] == '0);
    // wrap: zero to all ones
    st_d.wrap = st_q.primed && (st_q.timer_last == '0)
      && (&general_timer_count);
  end

  // register the copy
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign drop_half_pulse = st_q.half;
  assign timer_wrap_pulse = st_q.wrap;

endmodule : isuh_wrap

// [design/isuh_top.sv]
// interrupt status upper half with a classic wishbone slave
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "isuh_defs.svh"
module isuh_top #(
  parameter int READY_CYC = `ISUH_READY_CYC
) (
  input wire logic clk,
  input wire logic reset,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // event sources, same clock
  input wire logic timestamp_unit_event,
  input wire logic fabric_event,
  input wire logic second_port_transceiver_event,
  input wire logic first_port_transceiver_event,
  input wire logic transmit_stop_request,
  input wire logic transmitter_halted,
  input wire logic receiver_halted,
  input wire logic [31:0] drop_count,
  input wire logic buffer_loaded_pulse,
  input wire logic receive_count_done_pulse,
  input wire logic [15:0] general_timer_count,
  input wire logic power_event_pulse,
  input wire logic power_control_pending,
  input wire logic status_fifo_overflow_pulse,
  // results
  output logic master_irq,
  output logic power_irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    isuh_pkg::isuh_bus_e bus;
    isuh_pkg::isuh_half_t status;
    isuh_pkg::isuh_half_t enable;
    logic [31:0] rdata;
    logic ack;
    logic err;
    logic [7:0] ready_cnt;
    logic ready_done;
    logic irq;
    logic pirq;
  } isuh_top_s;

  isuh_top_s st_q;
  isuh_top_s st_d;

  // halt levels turned into one-cycle events
  logic [1:0] halt_rise;
  // counter watcher outputs
  logic drop_half;
  logic timer_wrap;
  // combinational helpers
  logic req;
  logic wr_status;
  logic [15:0] set_v;
  logic [15:0] clr_v;
  logic [15:0] wdat_hi;
  logic [15:0] ro_v;

  initial begin
    if (READY_CYC < 1 || READY_CYC > 255)
      $error("isuh_top: ready count out of range");
  end

  // ----------------------------------------------------------------------
  // event shapers
  // ----------------------------------------------------------------------
  isuh_edge #(
    .WIDTH(2)
  ) u_edge (
    .clk(clk),
    .reset(reset),
    .level_in({transmit_stop_request & transmitter_halted,
               receiver_halted}),
    .rise_out(halt_rise)
  );

  isuh_wrap #(
    .DROP_W(32),
    .TIMER_W(16)
  ) u_wrap (
    .clk(clk),
    .reset(reset),
    .drop_count(drop_count),
    .general_timer_count(general_timer_count),
    .drop_half_pulse(drop_half),
    .timer_wrap_pulse(timer_wrap)
  );

  // ----------------------------------------------------------------------
  // bus decode and next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    req = wb_cyc_i && wb_stb_i && (st_q.bus == isuh_pkg::ISUH_IDLE);
    wr_status = 1'b0;
    // only the upper two byte lanes reach the upper half
    wdat_hi = wb_dat_i[31:16] & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}};

    // summary bits follow their sources directly
    ro_v = 16'h0000;
    ro_v[`ISUH_BIT_TSU - 16] = timestamp_unit_event;
    ro_v[`ISUH_BIT_FABRIC - 16] = fabric_event;
    ro_v[`ISUH_BIT_PHY2 - 16] = second_port_transceiver_event;
    ro_v[`ISUH_BIT_PHY1 - 16] = first_port_transceiver_event;

    // sticky set sources; not gated by enable, except the software flag, which is set from enable bit 15
    set_v = 16'h0000;
    set_v[`ISUH_BIT_SWI - 16] = st_q.enable[`ISUH_SWREQ_BIT];
    set_v[`ISUH_BIT_READY - 16] = !st_q.ready_done
      && (st_q.ready_cnt == 8'(READY_CYC - 1));
    set_v[`ISUH_BIT_TXHALT - 16] = halt_rise[1];
    set_v[`ISUH_BIT_RXHALT - 16] = halt_rise[0];
    set_v[`ISUH_BIT_DROPHALF - 16] = drop_half;
    set_v[`ISUH_BIT_LOADED - 16] = buffer_loaded_pulse;
    set_v[`ISUH_BIT_RXDMA - 16] = receive_count_done_pulse;
    set_v[`ISUH_BIT_TIMER - 16] = timer_wrap;
    set_v[`ISUH_BIT_POWER - 16] = power_event_pulse;
    set_v[`ISUH_BIT_TRANSMIT_STATUS_OVERFLOW_FLAG - 16] = status_fifo_overflow_pulse;

    // ready counter runs once after reset release
    if (!st_q.ready_done) begin
      if (st_q.ready_cnt == 8'(READY_CYC - 1)) begin
        st_d.ready_done = 1'b1;
      end else begin
        st_d.ready_cnt = st_q.ready_cnt + 8'h01;
      end
    end

    // ack drops the cycle after it was given
    st_d.ack = 1'b0;
    st_d.err = 1'b0;
    st_d.bus = isuh_pkg::ISUH_IDLE;
    if (req) begin
      st_d.bus = isuh_pkg::ISUH_ACKED;
      st_d.rdata = 32'h0000_0000;
      if (wb_adr_i == `ISUH_OFS_STATUS) begin
        st_d.ack = 1'b1;
        st_d.rdata = {(st_q.status & ~`ISUH_RO_MASK) | ro_v, 16'h0000};
        wr_status = wb_we_i;
      end else if (wb_adr_i == `ISUH_OFS_ENABLE) begin
        st_d.ack = 1'b1;
        st_d.rdata = {st_q.enable, 16'h0000};
        if (wb_we_i) begin
          // enables change the output gating; bit 15 also requests the software flag
          st_d.enable = wdat_hi & (`ISUH_W1C_MASK | `ISUH_RO_MASK);
          st_d.enable[`ISUH_SWREQ_BIT] = wdat_hi[`ISUH_SWREQ_BIT];
        end
      end else if (wb_adr_i == `ISUH_OFS_SOURCE) begin
        // raw source view, for diagnosis
        st_d.ack = 1'b1;
        st_d.rdata = {ro_v, 15'h0000, power_control_pending};
      end else begin
        // unmapped address answers with an error
        st_d.err = 1'b1;
      end
    end

    // write-one clears; reserved and summary bits never written
    clr_v = wr_status ? (wdat_hi & `ISUH_W1C_MASK) : 16'h0000;
    // power bit stays while control bits still pending
    if (power_control_pending) begin
      clr_v[`ISUH_BIT_POWER - 16] = 1'b0;
    end
    // set beats clear in the same cycle
    st_d.status = ((st_q.status & ~clr_v) | set_v)
      & `ISUH_W1C_MASK;

    // master line: any enabled active bit, no interval
    st_d.irq = |(((st_d.status | ro_v)) & st_d.enable
      & (`ISUH_W1C_MASK | `ISUH_RO_MASK));
    // power line goes straight through, never held off
    st_d.pirq = st_d.status[`ISUH_BIT_POWER - 16]
      & st_d.enable[`ISUH_BIT_POWER - 16];
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
      st_q.status <= `ISUH_STATUS_RST;
      st_q.enable <= `ISUH_ENABLE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign wb_dat_o = st_q.rdata;
  assign wb_ack_o = st_q.ack;
  assign wb_err_o = st_q.err;
  assign master_irq = st_q.irq;
  assign power_irq = st_q.pirq;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_w1c_write(int b);
    wb_cyc_i && wb_stb_i && wb_we_i && st_q.bus == isuh_pkg::ISUH_IDLE
      && wb_adr_i == `ISUH_OFS_STATUS && wb_dat_i[b] && wb_sel_i[b/8];
  endsequence

  AST_RESET_ZERO: assert property (@(posedge clk)
    $fell(reset) |-> st_q.status == 16'h0000)
    else $error("status not zero after reset");

  AST_ENABLE_NO_GATE: assert property (@(posedge clk)
    disable iff (reset) buffer_loaded_pulse |=> st_q.status[5])
    else $error("capture gated by enable");

  AST_SWI_SET: assert property (@(posedge clk)
    disable iff (reset) st_q.enable[`ISUH_SWREQ_BIT] |=> st_q.status[15])
    else $error("software flag not set");

  AST_CLEAR: assert property (@(posedge clk)
    disable iff (reset)
    s_w1c_write(24) ##0 !halt_rise[0] |=> !st_q.status[8])
    else $error("write one did not clear");

  AST_READY: assert property (@(posedge clk)
    $fell(reset) |-> ##[1:256] st_q.status[14])
    else $error("ready flag never set");

  AST_TIMER: assert property (@(posedge clk)
    disable iff (reset) timer_wrap |=> st_q.status[3])
    else $error("timer wrap lost");

  AST_SET_WINS: assert property (@(posedge clk)
    disable iff (reset)
    s_w1c_write(16) ##0 status_fifo_overflow_pulse |=> st_q.status[0])
    else $error("set lost to clear");

  AST_POWER_HOLD: assert property (@(posedge clk)
    disable iff (reset)
    st_q.status[1] && power_control_pending |=> st_q.status[1])
    else $error("power bit cleared while pending");

  AST_MASTER: assert property (@(posedge clk)
    disable iff (reset) (|(st_q.status & st_q.enable & `ISUH_W1C_MASK))
      && !(wb_cyc_i && wb_stb_i) |=> master_irq)
    else $error("master line missing");

  AST_SUMMARY: assert property (@(posedge clk)
    disable iff (reset) st_q.ack && $past(wb_adr_i) == `ISUH_OFS_STATUS
      && !$past(wb_we_i) |-> wb_dat_o[28] == $past(fabric_event))
    else $error("fabric summary wrong");

  // ----------------------------------------------------------------------
  // further checks
  // ----------------------------------------------------------------------
  // a zero written at a sticky bit position must leave it alone
  sequence s_w0_write(int b);
    wb_cyc_i && wb_stb_i && wb_we_i && st_q.bus == isuh_pkg::ISUH_IDLE
      && wb_adr_i == `ISUH_OFS_STATUS && !wb_dat_i[b];
  endsequence

  // transmit halt: rise of request-and-halted sets the flag
  AST_TXHALT: assert property (@(posedge clk)
    disable iff (reset) halt_rise[1] |=> st_q.status[9])
    else $error("transmit halt event lost");

  // receive halt: rise of the halted level sets the flag
  AST_RXHALT: assert property (@(posedge clk)
    disable iff (reset) halt_rise[0] |=> st_q.status[8])
    else $error("receive halt event lost");

  // halfway crossing of the drop counter
  AST_DROPHALF: assert property (@(posedge clk)
    disable iff (reset) drop_half |=> st_q.status[7])
    else $error("drop counter halfway lost");

  // receive count moved out of the fifo
  AST_RXDMA: assert property (@(posedge clk)
    disable iff (reset) receive_count_done_pulse |=> st_q.status[4])
    else $error("receive count event lost");

  // power event captured even with the wake output unused
  AST_POWER_SET: assert property (@(posedge clk)
    disable iff (reset) power_event_pulse |=> st_q.status[1])
    else $error("power event lost");

  // status fifo overflow
  AST_TRANSMIT_STATUS_OVERFLOW_FLAG: assert property (@(posedge clk)
    disable iff (reset) status_fifo_overflow_pulse |=> st_q.status[0])
    else $error("status overflow lost");

  // reserved and summary positions never hold sticky state
  AST_RESERVED: assert property (@(posedge clk)
    disable iff (reset) st_q.status[6] == 1'b0 && st_q.status[2] == 1'b0
      && (st_q.status & `ISUH_RO_MASK) == 16'h0000)
    else $error("reserved or summary bit stored");

  // zero in the write keeps a set flag
  AST_ZERO_KEEPS: assert property (@(posedge clk)
    disable iff (reset)
    s_w0_write(25) ##0 st_q.status[9] |=> st_q.status[9])
    else $error("zero write cleared a flag");

  // clear of the power flag works once nothing is pending
  AST_POWER_CLEAR: assert property (@(posedge clk)
    disable iff (reset)
    s_w1c_write(17) ##0 (!power_control_pending && !power_event_pulse)
      |=> !st_q.status[1])
    else $error("power flag not cleared");

  // power line follows without any hold-off interval
  AST_POWER_LINE: assert property (@(posedge clk)
    disable iff (reset) st_q.status[1] && st_q.enable[1]
      && !(wb_cyc_i && wb_stb_i) |=> power_irq)
    else $error("power line held off");

endmodule : isuh_top

// [testbench/tb_interrupt_status_upper_half.sv]
// self-checking bench for the interrupt status upper half
`timescale 1ns/1ps
`include "isuh_defs.svh"
module tb_interrupt_status_upper_half;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic clk, reset; // 125 MHz clock, sync reset
  logic cyc, stb, we, ack, err; // wishbone handshake
  logic [7:0] adr; // byte address
  logic [3:0] sel; // byte lanes
  logic [31:0] wdat, rdat; // write and read data
  logic ts_ev, fab_ev, phy2_ev, phy1_ev; // mirrored levels
  logic stop_req, tx_halt, rx_halt; // halt levels
  logic [31:0] drop_cnt; // dropped frame counter
  logic [15:0] timer_cnt; // general timer
  logic loaded_p, rxdone_p, pwr_p, pwr_pend, tsfo_p; // pulses, pending
  logic master_irq, power_irq; // interrupt results
  int fails, n_tests; // mismatch and comparison counters
  logic [31:0] rd; // last read word
  logic er; // last error flag
  int bits [8] = '{25, 24, 23, 21, 20, 19, 17, 16}; // sticky bits
  localparam logic [7:0] A_ST = `ISUH_OFS_STATUS;
  localparam logic [7:0] A_EN = `ISUH_OFS_ENABLE;

  // small ready delay keeps the startup short
  isuh_top #(.READY_CYC(4)) dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .timestamp_unit_event(ts_ev), .fabric_event(fab_ev),
    .second_port_transceiver_event(phy2_ev),
    .first_port_transceiver_event(phy1_ev),
    .transmit_stop_request(stop_req), .transmitter_halted(tx_halt),
    .receiver_halted(rx_halt), .drop_count(drop_cnt),
    .buffer_loaded_pulse(loaded_p), .receive_count_done_pulse(rxdone_p),
    .general_timer_count(timer_cnt), .power_event_pulse(pwr_p),
    .power_control_pending(pwr_pend),
    .status_fifo_overflow_pulse(tsfo_p), .master_irq(master_irq),
    .power_irq(power_irq));

  // ----------------------------------------------------------------------
  // clock and tasks
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // verdict in one place, also reached from a timeout
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  // one classic cycle; ack and data taken at the rising edge ending the wait
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    if (ack !== 1'b1 && err !== 1'b1) begin
      chk("bus answer", 32'h1, 32'h0);
      report_and_stop();
    end
    rd = rdat;
    er = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk); // idle cycle between requests
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rchk

  // bounded wait for an interrupt line to reach a level
  task automatic wirq(input bit pw, input logic e, input string nm);
    logic v;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      v = pw ? power_irq : master_irq;
      if (v === e) break;
    end
    chk(nm, {31'h0, e}, {31'h0, v});
    @(posedge clk);
  endtask : wirq

  // raise one source event for a sticky bit, then quiet it again
  task automatic fire(input int b);
    @(posedge clk);
    case (b)
      25: begin
        stop_req <= 1'b1;
        tx_halt <= 1'b1;
      end
      24: rx_halt <= 1'b1;
      23: drop_cnt <= 32'h80000000;
      21: loaded_p <= 1'b1;
      20: rxdone_p <= 1'b1;
      19: timer_cnt <= 16'hFFFF;
      17: pwr_p <= 1'b1;
      default: tsfo_p <= 1'b1;
    endcase
    @(posedge clk);
    {stop_req, tx_halt, rx_halt, loaded_p, rxdone_p, pwr_p, tsfo_p} <= '0;
    drop_cnt <= 32'h7FFFFFFF;
    timer_cnt <= 16'h0000;
    repeat (2) @(posedge clk);
  endtask : fire

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {cyc, stb, we, ts_ev, fab_ev, phy2_ev, phy1_ev} = '0;
    {stop_req, tx_halt, rx_halt, loaded_p, rxdone_p, pwr_p, tsfo_p} = '0;
    {adr, wdat, pwr_pend} = '0;
    sel = 4'hF;
    drop_cnt = 32'h7FFFFFFF;
    timer_cnt = 16'h0000;
    fails = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    rchk(A_ST, 32'h40000000, "ready");
    rchk(A_EN, 32'h0, "enable reset");
    bus(1'b1, A_ST, 32'h40000000);
    rchk(A_ST, 32'h0, "ready clear");
    $display("test reset done");
    // mirrors follow their sources and ignore writes
    {ts_ev, fab_ev, phy2_ev, phy1_ev} <= 4'hF;
    rchk(A_ST, 32'h3C000000, "mirrors");
    bus(1'b1, A_ST, 32'hFFFFFFFF);
    rchk(A_ST, 32'h3C000000, "mirror write");
    {ts_ev, fab_ev, phy2_ev, phy1_ev} <= 4'h0;
    @(posedge clk);
    rchk(A_ST, 32'h0, "mirror drop");
    $display("test mirrors done");
    // sticky bits: captured with enables off, zero keeps, one clears
    foreach (bits[i]) begin
      fire(bits[i]);
      rchk(A_ST, 32'h1 << bits[i], "sticky set");
      bus(1'b1, A_ST, ~(32'h1 << bits[i]));
      rchk(A_ST, 32'h1 << bits[i], "zero keeps");
      bus(1'b1, A_ST, 32'h1 << bits[i]);
      rchk(A_ST, 32'h0, "one clears");
    end
    $display("test sticky done");
    // power bit held while control bits pending
    pwr_pend <= 1'b1;
    fire(17);
    bus(1'b1, A_ST, 32'h00020000);
    rchk(A_ST, 32'h00020000, "power held");
    rchk(`ISUH_OFS_SOURCE, 32'h1, "source view");
    pwr_pend <= 1'b0;
    bus(1'b1, A_ST, 32'h00020000);
    rchk(A_ST, 32'h0, "power clear");
    $display("test power clear done");
    // upper lanes off: a write there must not reach the flags
    fire(16);
    sel <= 4'h3;
    bus(1'b1, A_ST, 32'h00010000);
    sel <= 4'hF;
    rchk(A_ST, 32'h00010000, "lane off keeps");
    bus(1'b1, A_ST, 32'h00010000);
    rchk(A_ST, 32'h0, "lane on clears");
    $display("test byte lanes done");
    // software flag drives master line while requested
    bus(1'b1, A_EN, 32'h80000000);
    rchk(A_ST, 32'h80000000, "soft set");
    wirq(1'b0, 1'b1, "master on");
    bus(1'b1, A_EN, 32'h0);
    bus(1'b1, A_ST, 32'h80000000);
    rchk(A_ST, 32'h0, "soft clear");
    wirq(1'b0, 1'b0, "master off");
    bus(1'b1, A_EN, 32'h00200000);
    fire(21);
    wirq(1'b0, 1'b1, "enabled bit");
    bus(1'b1, A_ST, 32'h00200000);
    wirq(1'b0, 1'b0, "enabled clear");
    $display("test master done");
    // power line has no hold-off interval
    bus(1'b1, A_EN, 32'h00020000);
    fire(17);
    wirq(1'b1, 1'b1, "power on");
    bus(1'b1, A_ST, 32'h00020000);
    wirq(1'b1, 1'b0, "power off");
    $display("test power line done");
    // unmapped place answers with error
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    $display("test unmapped done");
    report_and_stop();
  end
endmodule : tb_interrupt_status_upper_half
